// *** verilog/lfs_defs.vh ***
// Constants for the LED fault supervisor
`ifndef LFS_DEFS_VH
`define LFS_DEFS_VH

// -----------------------------------------------------------------------------
// Fault-delay levels, microvolts, counter unit is 1 uV
// -----------------------------------------------------------------------------
`define LFS_DLY_W          24
`define LFS_DLY_MAX_UV     24'd3600000
`define LFS_DLY_SD_UV      24'd2800000
`define LFS_DLY_RESTART_UV 24'd350000
// Charge per clock with a notional delay capacitor: uV per cycle
`define LFS_STEP_W         16
`define LFS_CHG_STEP       16'h0039
`define LFS_DIS_STEP       16'h0002

// -----------------------------------------------------------------------------
// Timing
// -----------------------------------------------------------------------------
`define LFS_CLK_MHZ        40
`define LFS_BLANK_NS       1600
`define LFS_BLANK_CYC      ((`LFS_BLANK_NS * `LFS_CLK_MHZ + 999) / 1000)
`define LFS_BLANK_W        7
`define LFS_SS_CYC_W       16
`define LFS_SS_CYC         16'h0FA0
// Edges from reset release until the strap pin has crossed both sync flops
`define LFS_STRAP_CYC      2'h2

// -----------------------------------------------------------------------------
// Input bit positions in the raw comparator vector
// -----------------------------------------------------------------------------
`define LFS_IN_N           10
`define LFS_B_SC_LO        0
`define LFS_B_SC_HI        1
`define LFS_B_OVP          2
`define LFS_B_UVP          3
`define LFS_B_CFB_LOW      4
`define LFS_B_ILIM         5
`define LFS_B_UNDERVOLTAGE_LOCKOUT         6
`define LFS_B_EN           7
`define LFS_B_TSD          8
`define LFS_B_THM          9

`endif

// *** verilog/lfs_dly_timer.v ***
// Fault-delay timer: up/down counter standing in for the delay capacitor
`timescale 1ns/1ps
`include "lfs_defs.vh"
module lfs_dly_timer (
	input  wire                     clk_sys,
	input  wire                     sys_rst,
	input  wire                     charge,
	input  wire                     discharge,
	input  wire                     hold_max,
	input  wire                     hold_sd,
	input  wire                     clear,
	input  wire [`LFS_STEP_W-1:0]   chg_step,
	input  wire [`LFS_STEP_W-1:0]   dis_step,
	output reg  [`LFS_DLY_W-1:0]    level
);

	wire [`LFS_DLY_W:0] up = {1'b0, level} + {{(`LFS_DLY_W+1-`LFS_STEP_W){1'b0}}, chg_step};
	wire [`LFS_DLY_W-1:0] dn_step = {{(`LFS_DLY_W-`LFS_STEP_W){1'b0}}, dis_step};

	always @(posedge clk_sys) begin
		if (sys_rst || clear) begin
			level <= {`LFS_DLY_W{1'b0}};
		end else if (hold_sd) begin
			level <= `LFS_DLY_SD_UV;
		end else if (hold_max) begin
			level <= `LFS_DLY_MAX_UV;
		end else if (charge) begin
			// Saturates at the upper clamp
			if (up >= {1'b0, `LFS_DLY_MAX_UV})
				level <= `LFS_DLY_MAX_UV;
			else
				level <= up[`LFS_DLY_W-1:0];
		end else if (discharge) begin
			if (level > dn_step)
				level <= level - dn_step;
			else
				level <= {`LFS_DLY_W{1'b0}};
		end
	end
endmodule

// *** verilog/lfs_fault_supervisor.v ***
// Fault supervisor for a three-string LED driver with boost controller
//
// Notes on behaviour
// - Type 1 or Type 2 fault charges the fault-delay timer at charge step.
// - Type 1 keeps regulating; timer saturates at upper limit, no shutdown.
// - Type 2 shuts down at threshold; without restart timer held at top.
// - Delay node forced to ground disables Type 2 shutdown; debug only.
// - Non-cathode fault clearing before shutdown discharges timer slowly.
// - LED-on-only faults freeze timer during LED-off time.
// - Short-sense detection blanked for a fixed time after each string turn-on.
// - Undervoltage, enable low, overtemp, thermistor: standby, no charge, soft-start.
// - Without auto-restart stay shut down until a Type 3 condition: undervoltage, enable low, overtemp or thermistor.
// - Strings-off output grounded at startup selects auto-restart mode.
// - Auto-restart discharges from shutdown level, restarts at restart level.
// - After overvoltage shutdown hold timer until overvoltage clears.
// - Auto-restart repeats shutdown, discharge, soft-start without limit.
// - Short-sense above first level is Type 1; clamp node, keep regulating.
// - Anode feedback above overvoltage level raises Type 2.
// - Anode over/undervoltage monitored in LED-on and LED-off periods.
// - Short-sense at short-circuit level raises Type 2.
// - Anode feedback below undervoltage level raises Type 2.
// - Cathode low at soft-start end latches Type 2 until shutdown.
`timescale 1ns/1ps
`include "lfs_defs.vh"
module lfs_fault_supervisor (
	input  wire                     clk_sys,
	input  wire                     sys_rst,
	input  wire                     short_sense_lo,
	input  wire                     short_sense_hi,
	input  wire                     output_overvoltage,
	input  wire                     anode_undervoltage,
	input  wire                     cathode_feedback_low,
	input  wire                     current_limit,
	input  wire                     undervoltage_lockout,
	input  wire                     enable,
	input  wire                     die_overtemp,
	input  wire                     led_thermistor_low,
	input  wire                     dim_on,
	input  wire                     dly_grounded,
	input  wire                     strings_off_in,
	input  wire [`LFS_STEP_W-1:0]   chg_step,
	input  wire [`LFS_STEP_W-1:0]   dis_step,
	output reg                      strings_off_output,
	output reg                      strings_off_oe_n,
	output reg                      regulate_en,
	output reg                      boost_en,
	output reg                      soft_start,
	output reg                      short_sense_clamp,
	output reg                      fault_type1,
	output reg                      fault_type2,
	output reg                      fault_type3,
	output reg                      auto_restart,
	output reg                      shutdown,
	output reg  [`LFS_DLY_W-1:0]    dly_level
);

	// -------------------------------------------------------------------------
	// States
	// -------------------------------------------------------------------------
	localparam [4:0] ST_STANDBY = 5'h01;
	localparam [4:0] ST_SOFT    = 5'h02;
	localparam [4:0] ST_RUN     = 5'h04;
	localparam [4:0] ST_SHUT    = 5'h08;
	localparam [4:0] ST_RESTART = 5'h10;

	// -------------------------------------------------------------------------
	// State decode
	// -------------------------------------------------------------------------
	// One-hot membership test; code may hold several states at once
	function in_state;
		input [4:0] st;
		input [4:0] code;
		begin
			in_state = |(st & code);
		end
	endfunction

	// -------------------------------------------------------------------------
	// Input synchronisers
	// -------------------------------------------------------------------------
	wire [`LFS_IN_N-1:0] raw_in;
	reg  [`LFS_IN_N-1:0] sync_a;
	reg  [`LFS_IN_N-1:0] sync_b;
	reg  [2:0]           misc_a;
	reg  [2:0]           misc_b;

	assign raw_in[`LFS_B_SC_LO]   = short_sense_lo;
	assign raw_in[`LFS_B_SC_HI]   = short_sense_hi;
	assign raw_in[`LFS_B_OVP]     = output_overvoltage;
	assign raw_in[`LFS_B_UVP]     = anode_undervoltage;
	assign raw_in[`LFS_B_CFB_LOW] = cathode_feedback_low;
	assign raw_in[`LFS_B_ILIM]    = current_limit;
	assign raw_in[`LFS_B_UNDERVOLTAGE_LOCKOUT]    = undervoltage_lockout;
	assign raw_in[`LFS_B_EN]      = enable;
	assign raw_in[`LFS_B_TSD]     = die_overtemp;
	assign raw_in[`LFS_B_THM]     = led_thermistor_low;

	// Comparator outputs are asynchronous to clk_sys
	always @(posedge clk_sys) begin
		if (sys_rst) begin
			sync_a <= {`LFS_IN_N{1'b0}};
			sync_b <= {`LFS_IN_N{1'b0}};
		end else begin
			sync_a <= raw_in;
			sync_b <= sync_a;
		end
	end

	// Dimming phase, delay-node ground and strap pin; the strap value is
	// not trusted until both flops have seen the pin
	always @(posedge clk_sys) begin
		if (sys_rst) begin
			misc_a <= 3'h0;
			misc_b <= 3'h0;
		end else begin
			misc_a <= {strings_off_in, dly_grounded, dim_on};
			misc_b <= misc_a;
		end
	end

	wire s_sc_lo  = sync_b[`LFS_B_SC_LO];
	wire s_sc_hi  = sync_b[`LFS_B_SC_HI];
	wire s_ovp    = sync_b[`LFS_B_OVP];
	wire s_uvp    = sync_b[`LFS_B_UVP];
	wire s_cfb_lo = sync_b[`LFS_B_CFB_LOW];
	wire s_ilim   = sync_b[`LFS_B_ILIM];
	wire s_undervoltage_lockout   = sync_b[`LFS_B_UNDERVOLTAGE_LOCKOUT];
	wire s_en     = sync_b[`LFS_B_EN];
	wire s_tsd    = sync_b[`LFS_B_TSD];
	wire s_thm    = sync_b[`LFS_B_THM];
	wire s_dim    = misc_b[0];
	wire s_dlygnd = misc_b[1];
	wire s_off_in = misc_b[2];

	// -------------------------------------------------------------------------
	// State and blanking
	// -------------------------------------------------------------------------
	reg  [4:0]               state;
	reg  [4:0]               next_state;
	reg  [`LFS_BLANK_W-1:0]  blank_cnt;
	reg  [`LFS_SS_CYC_W-1:0] ss_cnt;
	reg                      dim_prev;
	reg                      cath_latch;
	reg                      ovp_shut;
	reg                      strap_done;
	reg  [1:0]               strap_cnt;

	wire leds_on   = (state == ST_RUN) && s_dim;
	wire blank_end = (blank_cnt == `LFS_BLANK_CYC);
	wire sense_ok  = leds_on && blank_end;

	// Blanking counter restarts on every turn-on edge
	always @(posedge clk_sys) begin
		if (sys_rst) begin
			blank_cnt <= {`LFS_BLANK_W{1'b0}};
			dim_prev  <= 1'b0;
		end else begin
			dim_prev <= leds_on;
			if (!leds_on || !dim_prev)
				blank_cnt <= {`LFS_BLANK_W{1'b0}};
			else if (!blank_end)
				blank_cnt <= blank_cnt + {{(`LFS_BLANK_W-1){1'b0}}, 1'b1};
		end
	end

	// -------------------------------------------------------------------------
	// Fault sorting
	// -------------------------------------------------------------------------
	// Type 3: standby, no timer action
	wire t3 = s_undervoltage_lockout || !s_en || s_tsd || s_thm;
	// Anode faults seen in both LED phases
	wire afb_fault = (state == ST_RUN) && (s_ovp || s_uvp);
	// Short-sense faults only valid after blanking in LED-on time
	wire sc_short  = sense_ok && s_sc_hi;
	wire ilim_f    = (state == ST_RUN) && s_ilim;
	wire t2 = afb_fault || sc_short || ilim_f || cath_latch;
	wire t1 = sense_ok && s_sc_lo && !s_sc_hi;
	// Freeze outside the sensed window: LED-off time and the blanking time
	// after each turn-on, unless an always-monitored fault is present.
	// Without this the blanking time would bleed the timer every period.
	wire steady_fault = afb_fault || cath_latch || ilim_f;
	wire frozen = (state == ST_RUN) && !sense_ok && !steady_fault;
	wire dly_at_sd  = (dly_level >= `LFS_DLY_SD_UV);
	wire dly_at_rst = (dly_level <= `LFS_DLY_RESTART_UV);

	// -------------------------------------------------------------------------
	// Next-state logic
	// -------------------------------------------------------------------------
	// Type 3 drops every state to standby at once; a grounded delay node
	// keeps the run state from ever reaching shutdown
	always @* begin
		next_state = state;
		case (state)
			ST_STANDBY: begin
				if (!t3 && strap_done)
					next_state = ST_SOFT;
			end
			ST_SOFT: begin
				if (t3)
					next_state = ST_STANDBY;
				else if (ss_cnt == `LFS_SS_CYC)
					next_state = ST_RUN;
			end
			ST_RUN: begin
				if (t3)
					next_state = ST_STANDBY;
				else if (t2 && dly_at_sd && !s_dlygnd)
					next_state = ST_SHUT;
			end
			ST_SHUT: begin
				if (t3)
					next_state = ST_STANDBY;
				else if (auto_restart)
					next_state = ST_RESTART;
			end
			ST_RESTART: begin
				if (t3)
					next_state = ST_STANDBY;
				else if (!ovp_shut && dly_at_rst)
					next_state = ST_SOFT;
			end
			default: next_state = ST_STANDBY;
		endcase
	end

	// Outputs decode next_state so they change on the same edge as state
	always @(posedge clk_sys) begin
		if (sys_rst)
			state <= ST_STANDBY;
		else
			state <= next_state;
	end

	// -------------------------------------------------------------------------
	// Soft-start, cathode check, strap sampling
	// -------------------------------------------------------------------------
	always @(posedge clk_sys) begin
		if (sys_rst) begin
			ss_cnt       <= {`LFS_SS_CYC_W{1'b0}};
			cath_latch   <= 1'b0;
			ovp_shut     <= 1'b0;
			strap_done   <= 1'b0;
			strap_cnt    <= 2'h0;
			auto_restart <= 1'b0;
		end else begin
			if (state == ST_SOFT)
				ss_cnt <= ss_cnt + {{(`LFS_SS_CYC_W-1){1'b0}}, 1'b1};
			else
				ss_cnt <= {`LFS_SS_CYC_W{1'b0}};
			// Latched so the timer runs to shutdown even if the short clears
			if (state == ST_SOFT && next_state == ST_RUN && s_cfb_lo)
				cath_latch <= 1'b1;
			else if (state != ST_RUN)
				cath_latch <= 1'b0;
			if (state == ST_RUN && next_state == ST_SHUT)
				ovp_shut <= s_ovp;
			else if (!s_ovp)
				ovp_shut <= 1'b0;
			// Strap read once the pin has passed both sync flops; the
			// flops hold their reset value for the first two edges
			if (!strap_done) begin
				if (strap_cnt == `LFS_STRAP_CYC) begin
					strap_done   <= 1'b1;
					auto_restart <= !s_off_in;
				end else begin
					strap_cnt <= strap_cnt + 2'h1;
				end
			end
		end
	end

	// -------------------------------------------------------------------------
	// Timer control
	// -------------------------------------------------------------------------
	wire any_fault = t1 || t2;
	wire tm_clear  = (state == ST_STANDBY) || (state == ST_SOFT);
	// Auto-restart discharge always starts from the shutdown level
	wire tm_hold_sd  = ((state == ST_RESTART) && ovp_shut)
	                   || ((state == ST_SHUT) && auto_restart);
	wire tm_hold_max = (state == ST_SHUT) && !auto_restart;
	// Type 3 is leaving the run state: no charge step on the way out
	wire tm_charge = (state == ST_RUN) && !frozen && any_fault
	                 && !t3;
	wire tm_dis    = ((state == ST_RUN) && !frozen && !any_fault)
	                 || (state == ST_RESTART) || (state == ST_SHUT);
	wire [`LFS_DLY_W-1:0] tm_level;

	lfs_dly_timer u_timer (
		.clk_sys   (clk_sys),
		.sys_rst   (sys_rst),
		.charge    (tm_charge),
		.discharge (tm_dis),
		.hold_max  (tm_hold_max),
		.hold_sd   (tm_hold_sd),
		.clear     (tm_clear || s_dlygnd),
		.chg_step  (chg_step),
		.dis_step  (dis_step),
		.level     (tm_level)
	);

	always @* dly_level = tm_level;

	// -------------------------------------------------------------------------
	// Outputs
	// -------------------------------------------------------------------------
	always @(posedge clk_sys) begin
		if (sys_rst) begin
			regulate_en        <= 1'b0;
			boost_en           <= 1'b0;
			soft_start         <= 1'b0;
			short_sense_clamp  <= 1'b0;
			fault_type1        <= 1'b0;
			fault_type2        <= 1'b0;
			fault_type3        <= 1'b0;
			shutdown           <= 1'b0;
		end else begin
			regulate_en        <= in_state(next_state, ST_RUN);
			boost_en           <= in_state(next_state, ST_RUN | ST_SOFT);
			soft_start         <= in_state(next_state, ST_SOFT);
			short_sense_clamp  <= t1;
			fault_type1        <= t1;
			fault_type2        <= t2;
			fault_type3        <= t3;
			shutdown           <= in_state(next_state, ST_SHUT | ST_RESTART);
		end
	end

	// -------------------------------------------------------------------------
	// Strings-off pin
	// -------------------------------------------------------------------------
	// Released until the strap has been read, so a grounded strap is not fought
	always @(posedge clk_sys) begin
		if (sys_rst) begin
			strings_off_output <= 1'b1;
			strings_off_oe_n   <= 1'b1;
		end else begin
			// High while strings are off, low only in LED-on time
			strings_off_output <= !(in_state(next_state, ST_RUN) && s_dim);
			strings_off_oe_n   <= !strap_done;
		end
	end
endmodule

// *** verification/lfs_plant.sv ***
// Far-side model of the strings-off pin and its board strap
`timescale 1ns/1ps
module lfs_plant (
	input  wire strap_gnd,
	input  wire strings_off_output,
	input  wire strings_off_oe_n,
	output wire strings_off_in
);
	// A grounded strap beats the driver; a released pin floats up
	assign strings_off_in = strap_gnd ? 1'h0 : (strings_off_oe_n ? 1'h1 : strings_off_output);
endmodule

// *** verification/lfs_checker.sv ***
// Concurrent checks on the fault supervisor ports
`timescale 1ns/1ps
`include "lfs_defs.vh"
module lfs_checker (
	input wire                  clk_sys,
	input wire                  sys_rst,
	input wire                  dly_grounded,
	input wire                  output_overvoltage,
	input wire                  boost_en,
	input wire                  short_sense_clamp,
	input wire                  fault_type1,
	input wire                  fault_type3,
	input wire                  auto_restart,
	input wire                  shutdown,
	input wire [`LFS_DLY_W-1:0] dly_level
);
	// ----------
	// Properties
	// ----------
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	dly_ceiling_a: assert property (dly_level <= `LFS_DLY_MAX_UV)
		else $error("delay level above ceiling");
	clamp_follow_a: assert property (fault_type1 |-> ##[0:1] short_sense_clamp)
		else $error("clamp missing on type 1");
	standby_now_a: assert property ($rose(fault_type3) |-> ##[0:2] !boost_en)
		else $error("boost still on in standby");
	standby_clear_a: assert property (fault_type3 [*4] |-> dly_level == 24'h000000)
		else $error("delay charged in standby");
	grounded_safe_a: assert property (
		dly_grounded [*5] |-> dly_level == 24'h000000 && !$rose(shutdown))
		else $error("shutdown with delay grounded");
	shut_threshold_a: assert property (
		$rose(shutdown) |-> dly_level >= `LFS_DLY_SD_UV || $past(dly_level) >= `LFS_DLY_SD_UV)
		else $error("shutdown below threshold");
	shut_top_a: assert property (
		(!auto_restart && shutdown) [*3] |-> dly_level == `LFS_DLY_MAX_UV)
		else $error("delay not held at top");
	restart_level_a: assert property (
		$fell(shutdown) && auto_restart |-> !boost_en || $past(dly_level) <= `LFS_DLY_RESTART_UV)
		else $error("restart above restart level");
	overvolt_hold_a: assert property (
		(shutdown && auto_restart && output_overvoltage) [*4] |-> dly_level == `LFS_DLY_SD_UV)
		else $error("delay left threshold during overvoltage");
endmodule
bind lfs_fault_supervisor lfs_checker u_lfs_checker (.clk_sys(clk_sys), .sys_rst(sys_rst),
	.dly_grounded(dly_grounded), .output_overvoltage(output_overvoltage), .boost_en(boost_en),
	.short_sense_clamp(short_sense_clamp), .fault_type1(fault_type1), .fault_type3(fault_type3),
	.auto_restart(auto_restart), .shutdown(shutdown), .dly_level(dly_level));

// *** verification/lfs_fault_supervisor_test.sv ***
// Self-checking bench for the LED fault supervisor
`timescale 1ns/1ps
`include "lfs_defs.vh"
module lfs_fault_supervisor_test;
	logic        clk_sys, sys_rst, s_lo, s_hi, a_ov, a_uv, c_low, i_lim;
	logic        v_lock, en, hot, th_low, dim, gnd, strap;
	logic [15:0] chg, dis;
	wire         so_out, so_oe_n, so_in, reg_en, bst, ss, clamp, t1, t2, t3, auto, shut;
	wire  [23:0] dly;
	wire  [4:0]  obs;
	integer      num_errors, n_tests, seed, n, k, kd, i, a;
	localparam   W_SHUT = 0, W_SS = 1, W_RUN = 2, W_T2 = 3, W_T1 = 4;
	assign obs = {t1, t2, reg_en, ss, shut};
	lfs_fault_supervisor u_lfs_fault_supervisor (
		.clk_sys(clk_sys), .sys_rst(sys_rst), .short_sense_lo(s_lo), .short_sense_hi(s_hi),
		.output_overvoltage(a_ov), .anode_undervoltage(a_uv), .cathode_feedback_low(c_low),
		.current_limit(i_lim), .undervoltage_lockout(v_lock), .enable(en), .die_overtemp(hot),
		.led_thermistor_low(th_low), .dim_on(dim), .dly_grounded(gnd), .strings_off_in(so_in),
		.chg_step(chg), .dis_step(dis), .strings_off_output(so_out), .strings_off_oe_n(so_oe_n),
		.regulate_en(reg_en), .boost_en(bst), .soft_start(ss), .short_sense_clamp(clamp),
		.fault_type1(t1), .fault_type2(t2), .fault_type3(t3), .auto_restart(auto),
		.shutdown(shut), .dly_level(dly));
	lfs_plant u_lfs_plant (.strap_gnd(strap), .strings_off_output(so_out),
		.strings_off_oe_n(so_oe_n), .strings_off_in(so_in));
	initial begin
		clk_sys = 1'h0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	function automatic [31:0] lfsr(input [31:0] v);
		lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	task print_verdict;
		$display("checks %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task check(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	// Bounded wait; running out is counted and ends the run
	task wait_on(input integer sel, input logic val, input integer lim);
		n = 0;
		while (obs[sel] !== val && n < lim) begin
			@(negedge clk_sys);
			n++;
		end
		check("wait", val, obs[sel]);
		if (obs[sel] !== val)
			print_verdict;
	endtask
	// Model slope over four clocks, after two clocks for the syncs to settle
	task rate(input string what, input integer step, input integer dir);
		repeat (2) @(negedge clk_sys);
		a = dly;
		repeat (4) @(negedge clk_sys);
		check(what, a + dir * 4 * step, dly);
	endtask
	task do_reset(input logic s);
		strap = s;
		sys_rst = 1'h1;
		repeat (4) @(negedge clk_sys);
		sys_rst = 1'h0;
		repeat (4) @(negedge clk_sys);
		check("auto", s, auto);
		check("pin_oe_n", 0, so_oe_n);
		wait_on(W_RUN, 1, 4100);
	endtask
	// ---------
	// Scenarios
	// ---------
	initial begin
		{sys_rst, s_lo, s_hi, a_ov, a_uv, c_low, i_lim, v_lock, hot, th_low, dim, gnd} = 12'h800;
		en = 1'h1;
		strap = 1'h0;
		num_errors = 0;
		n_tests = 0;
		seed = lfsr(32'h134A6);
		chg = 16'h8000 | seed[14:0];
		dis = 16'h8000 | seed[30:16];
		k = (`LFS_DLY_SD_UV + chg - 1) / chg;
		kd = (`LFS_DLY_SD_UV - `LFS_DLY_RESTART_UV + dis - 1) / dis;
		do_reset(1'h0);
		s_lo = 1'h1;
		repeat (5) begin
			dim = 1'h1;
			repeat (40) @(negedge clk_sys);
			dim = 1'h0;
			repeat (20) @(negedge clk_sys);
		end
		check("blanked", 0, {t1, dly});
		dim = 1'h1;
		wait_on(W_T1, 1, 80);
		check("strings_off", 0, so_out);
		check("clamp", 1, clamp & reg_en);
		rate("charge", chg, 1);
		dim = 1'h0;
		rate("freeze", chg, 0);
		check("strings_off", 1, so_out);
		dim = 1'h1;
		for (i = 0; i < 300 && dly !== `LFS_DLY_MAX_UV; i++)
			@(negedge clk_sys);
		check("ceiling", {1'h0, `LFS_DLY_MAX_UV}, {shut, dly});
		s_lo = 1'h0;
		rate("discharge", dis, -1);
		repeat (150) @(negedge clk_sys);
		check("empty", 0, dly);
		dim = 1'h0;
		for (i = 0; i < 3; i++) begin
			{a_ov, a_uv, i_lim} = 3'h4 >> i;
			wait_on(W_SHUT, 1, k + 12);
			check("delay", 1, n >= k && n <= k + 8);
			repeat (3) @(negedge clk_sys);
			check("top", `LFS_DLY_MAX_UV, dly);
			{a_ov, a_uv, i_lim} = 3'h0;
			repeat (50) @(negedge clk_sys);
			check("latched", 1, shut);
			en = 1'h0;
			wait_on(W_SHUT, 0, 6);
			en = 1'h1;
			wait_on(W_SS, 1, 8);
			wait_on(W_RUN, 1, 4100);
		end
		gnd = 1'h1;
		a_uv = 1'h1;
		repeat (200) @(negedge clk_sys);
		check("grounded", 0, {shut, dly});
		{gnd, a_uv} = 2'h0;
		for (i = 0; i < 4; i++) begin
			{v_lock, hot, th_low} = 3'h4 >> i;
			en = (i != 3);
			a_ov = 1'h1;
			repeat (6) @(negedge clk_sys);
			check("standby", 3'h4, {t3, bst, |dly});
			{v_lock, hot, th_low, a_ov} = 4'h0;
			en = 1'h1;
			wait_on(W_SS, 1, 8);
		end
		c_low = 1'h1;
		wait_on(W_RUN, 1, 4100);
		wait_on(W_T2, 1, 6);
		c_low = 1'h0;
		wait_on(W_SHUT, 1, k + 12);
		do_reset(1'h1);
		{s_lo, s_hi, dim} = 3'h7;
		for (i = 0; i < 2; i++) begin
			wait_on(W_RUN, 1, 4100);
			wait_on(W_SHUT, 1, k + 80);
			wait_on(W_SHUT, 0, kd + 12);
			check("restart", 1, n >= kd && n <= kd + 8 && ss);
		end
		{s_lo, s_hi} = 2'h0;
		wait_on(W_RUN, 1, 4100);
		a_ov = 1'h1;
		wait_on(W_SHUT, 1, k + 12);
		repeat (20) @(negedge clk_sys);
		check("hold", `LFS_DLY_SD_UV, dly);
		a_ov = 1'h0;
		wait_on(W_SHUT, 0, kd + 12);
		print_verdict;
	end
endmodule
